// ===== logic/sync_ctrl_pkg.sv
// Constants and carriers for the clock divider sync control block.
// Assumes a single core clock domain and the plain register port of the top module.
package sync_ctrl_pkg;

	// Register map, byte offsets on the 8-bit address port.
	localparam logic [7:0] DIVIDER_SYNC_CONTROL_ADDR = 8'h3a;

	// Field positions inside the divider sync control register.
	localparam int MASTER_EN_BIT = 0;
	localparam int DIV_EN_BIT = 1;
	localparam int NEXT_ONLY_BIT = 2;

	// Reset value of the control register: everything off to save power.
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Value read back from an unmapped address.
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Control fields as one carrier.
	typedef struct packed {
		logic next_only;
		logic div_en;
		logic master_en;
	} sync_ctrl_t;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : sync_ctrl_pkg

// ===== logic/sync_edge_detect.sv
// Two-stage synchroniser plus rising edge detector for the external sync pin.
// Assumes the pin is asynchronous to CORE_CLK and pulses last at least two cycles.
`timescale 1ns/1ps
`default_nettype none
module sync_edge_detect (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic rise
);

	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic last_q, last_d;

	// Next values; only the second stage and its delayed copy feed the edge logic.
	always_comb begin
		meta_d = pin;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// Register stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	// A long pulse yields exactly one event on its leading edge.
	assign rise = sync_q & ~last_q;

	////////////////////////////////////////////////////////////////////////////

	// A rise is never followed by a second rise in the next cycle.
	single_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
		rise |=> !rise) else $error("edge detector fired on two cycles running");

endmodule : sync_edge_detect
`default_nettype wire

// ===== logic/divider_sync_control.sv
// Sync control for the converter's input clock divider.
// Assumes a software register port on CORE_CLK and an asynchronous sync pin.
// How it works
// - Master enable off keeps all sync inactive.
// - Pulse reaches divider only with both enables.
// - No next-only: divider realigns every pulse.
// - Next-only: first pulse aligns, later ignored.
// - After next-only alignment, divider enable self-clears.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module divider_sync_control (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic SYNC_IN,
	output logic SYNC_BUF_EN,
	output logic DIV_ALIGN
);

	sync_ctrl_pkg::reg_req_t req;
	sync_ctrl_pkg::sync_ctrl_t ctrl_q, ctrl_d;
	logic [7:0] rdata_q, rdata_d;
	logic align_q, align_d;
	logic sync_rise;
	logic gate_open;
	logic ctrl_write;

	// Bundle the register port so the decode below reads as one request.
	assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

	// A write that targets the control register; other addresses leave it alone.
	assign ctrl_write = req.wr && (req.addr == sync_ctrl_pkg::DIVIDER_SYNC_CONTROL_ADDR);

	////////////////////////////////////////////////////////////////////////////

	// Pin synchroniser and edge detector.
	sync_edge_detect edge_u (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.pin(SYNC_IN),
		.rise(sync_rise)
	);

	// The gate needs both enables; the master alone only powers the buffer.
	assign gate_open = ctrl_q.master_en & ctrl_q.div_en;

	////////////////////////////////////////////////////////////////////////////

	// Control register next value. The hardware self-clear wins over a software
	// write in the same cycle, so an alignment is never followed by a stale enable.
	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_write) begin
			ctrl_d.master_en = req.wdata[sync_ctrl_pkg::MASTER_EN_BIT];
			ctrl_d.div_en = req.wdata[sync_ctrl_pkg::DIV_EN_BIT];
			ctrl_d.next_only = req.wdata[sync_ctrl_pkg::NEXT_ONLY_BIT];
		end
		if (gate_open && sync_rise && ctrl_q.next_only) begin
			ctrl_d.div_en = 1'b0;
		end
	end

	// Alignment pulse: one cycle per accepted edge, every edge in continuous mode.
	always_comb begin
		align_d = gate_open & sync_rise;
	end

	// Read data for the cycle after the strobe; open bits read as zero.
	always_comb begin
		rdata_d = rdata_q;
		if (req.rd) begin
			if (req.addr == sync_ctrl_pkg::DIVIDER_SYNC_CONTROL_ADDR) begin
				rdata_d = {5'h00, ctrl_q};
			end else begin
				rdata_d = sync_ctrl_pkg::UNMAPPED_READ;
			end
		end else begin
			rdata_d = 8'h00;
		end
	end

	// Control register. Reset leaves every enable low, so the sync buffer draws
	// no power until software asks for it.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_q <= sync_ctrl_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Alignment pulse register. It costs a cycle of latency but keeps the
	// divider's realign input free of glitches from the edge logic.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			align_q <= 1'b0;
		end else begin
			align_q <= align_d;
		end
	end

	// Read data register.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs come straight from flip-flops.
	assign REG_RDATA = rdata_q;
	assign DIV_ALIGN = align_q;
	assign SYNC_BUF_EN = ctrl_q.master_en;

	////////////////////////////////////////////////////////////////////////////

	// Timing of one alignment, in CORE_CLK edges after the pin rises: the first
	// edge loads the first synchroniser stage, the second loads the second stage,
	// which raises the edge flag, and the third registers DIV_ALIGN.
	// Pulses shorter than two cycles may be missed; that is the price of the
	// two-stage synchroniser.

	// No alignment ever leaves while the master enable was off.
	master_gate_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) DIV_ALIGN |-> $past(ctrl_q.master_en))
		else $error("align without master enable");

	// With the master enable low the divider sees nothing in the next cycle.
	master_off_quiet_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) !ctrl_q.master_en |=> !DIV_ALIGN)
		else $error("align while master enable low");

	// A register write sets the buffer power bit one cycle later, so software
	// can leave the buffer unpowered whenever sync is unused.
	buffer_power_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) ctrl_write
		|=> SYNC_BUF_EN == $past(REG_WDATA[sync_ctrl_pkg::MASTER_EN_BIT]))
		else $error("buffer enable did not follow write");

	// No alignment while the divider enable was off.
	divider_gate_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) DIV_ALIGN |-> $past(ctrl_q.div_en))
		else $error("align without divider enable");

	// With the divider enable low the divider sees nothing in the next cycle.
	divider_off_quiet_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) !ctrl_q.div_en |=> !DIV_ALIGN)
		else $error("align while divider enable low");

	// With both enables high every seen edge reaches the divider.
	gate_pass_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) (gate_open && sync_rise) |=> DIV_ALIGN)
		else $error("open gate dropped a pulse");

	// Continuous mode passes each accepted edge.
	continuous_pass_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(gate_open && sync_rise && !ctrl_q.next_only) |=> DIV_ALIGN)
		else $error("continuous mode dropped a pulse");

	// Continuous mode keeps the divider enable after an alignment, unless
	// software rewrites the register in the same cycle.
	continuous_keep_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(gate_open && sync_rise && !ctrl_q.next_only && !ctrl_write)
		|=> ctrl_q.div_en)
		else $error("continuous mode lost divider enable");

	// Next-only mode: after an alignment, next edges are ignored.
	next_only_once_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(gate_open && sync_rise && ctrl_q.next_only) |=> !gate_open)
		else $error("next-only mode still open after align");

	// Once closed in next-only mode the gate stays closed until software
	// writes the register again.
	next_only_keep_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(ctrl_q.next_only && !ctrl_q.div_en && !ctrl_write)
		|=> !ctrl_q.div_en)
		else $error("next-only gate reopened by itself");

	// Self-clear of the divider enable after a next-only alignment.
	self_clear_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(gate_open && sync_rise && ctrl_q.next_only) |=> (!ctrl_q.div_en && DIV_ALIGN))
		else $error("divider enable not cleared");

	// The divider enable reads low while a next-only alignment leaves.
	align_closes_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(DIV_ALIGN && $past(ctrl_q.next_only)) |-> !ctrl_q.div_en)
		else $error("next-only align left enable set");

	// A held input gives one alignment only.
	one_event_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) DIV_ALIGN |=> !DIV_ALIGN)
		else $error("long pulse gave two alignments");

	////////////////////////////////////////////////////////////////////////////

	// Read data of the register match the control state one cycle later.
	read_back_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(REG_RD && REG_ADDR == sync_ctrl_pkg::DIVIDER_SYNC_CONTROL_ADDR)
		|=> REG_RDATA == {5'h00, $past(ctrl_q)})
		else $error("read back mismatch");

	// A control write lands the next-only field one cycle later.
	field_write_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		ctrl_write |=> ctrl_q.next_only == $past(REG_WDATA[sync_ctrl_pkg::NEXT_ONLY_BIT]))
		else $error("next-only field did not follow write");

	// Writes to any other address leave the software fields untouched.
	write_ignore_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(REG_WR && !ctrl_write) |=> ($stable(ctrl_q.master_en) && $stable(ctrl_q.next_only)))
		else $error("foreign write changed the register");

	// Unmapped reads return the fixed filler value.
	unmapped_read_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B)
		(REG_RD && REG_ADDR != sync_ctrl_pkg::DIVIDER_SYNC_CONTROL_ADDR)
		|=> REG_RDATA == sync_ctrl_pkg::UNMAPPED_READ)
		else $error("unmapped read not filler");

	// Read data stand for one cycle only and are zero otherwise.
	read_idle_a: assert property (@(posedge CORE_CLK)
		disable iff (!RST_B) !REG_RD |=> REG_RDATA == 8'h00)
		else $error("read data not zero when idle");

endmodule : divider_sync_control
`default_nettype wire

// ===== verification/sync_pulse_source.sv
// Board sync pulse source that drives the sync pin for a set number of cycles.
// Assumes one clock shared with the block under test.
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_source (
	input wire logic clk,
	input wire logic fire,
	input wire logic [3:0] width,
	output logic pulse
);
	logic [3:0] left_q = 4'h0;
	// The pin idles low, so a pulse always gives the block a clean rising edge.
	always @(posedge clk) begin
		if (fire) left_q <= width;
		else if (left_q != 4'h0) left_q <= left_q - 4'h1;
	end
	// The pin stays high while cycles of the current pulse remain.
	assign pulse = (left_q != 4'h0);
endmodule : sync_pulse_source
`default_nettype wire

// ===== verification/divider_sync_control_test.sv
// Register and sync pulse tests for the divider sync control block.
// Assumes the design files and the pulse source are compiled first.
`timescale 1ns/1ps
`default_nettype none
module divider_sync_control_test;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fire = 1'b0;
	logic [3:0] width = 4'h2;
	logic [7:0] rdata;
	logic pin, buf_en, align;
	int n_fail = 0;
	int checked = 0;
	int aligns = 0;
	always #12.5 clk = ~clk;
	// Count divider realign pulses.
	always @(posedge clk) if (align === 1'b1) aligns <= aligns + 1;
	divider_sync_control dut_u (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.SYNC_IN(pin), .SYNC_BUF_EN(buf_en), .DIV_ALIGN(align));
	sync_pulse_source src_u (.clk(clk), .fire(fire), .width(width), .pulse(pin));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask : chk
	task automatic wrr(logic [7:0] a, logic [7:0] d);
		@(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask : wrr
	// Read data stand only in the cycle after the strobe, then drop to zero.
	task automatic rdchk(logic [7:0] a, logic [7:0] exp);
		@(posedge clk) {rd, addr} <= {1'b1, a};
		@(posedge clk) rd <= 1'b0;
		#1 chk("read data", exp, rdata);
		@(posedge clk) #1 chk("read idle", 8'h00, rdata);
	endtask : rdchk
	// Long idle gap after each pulse lets the realign latency settle.
	task automatic pulse(logic [3:0] w, logic [7:0] exp);
		int base;
		base = aligns;
		@(posedge clk) {fire, width} <= {1'b1, w};
		@(posedge clk) fire <= 1'b0;
		repeat (24) @(posedge clk);
		#1 chk("align count", exp, 8'(aligns - base));
	endtask : pulse
	task automatic print_verdict();
		$display("Checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdchk(8'h3a, 8'h00);
		rdchk(8'h10, 8'h00);
		wrr(8'h3a, 8'h02);
		chk("buffer enable", 8'h00, {7'h0, buf_en});
		pulse(4'h3, 8'h00);
		wrr(8'h3a, 8'h01);
		chk("buffer enable", 8'h01, {7'h0, buf_en});
		pulse(4'h3, 8'h00);
		wrr(8'h3a, 8'hff);
		rdchk(8'h3a, 8'h07);
		wrr(8'h3a, 8'h03);
		pulse(4'h6, 8'h01);
		pulse(4'h2, 8'h01);
		rdchk(8'h3a, 8'h03);
		wrr(8'h3a, 8'h07);
		pulse(4'h2, 8'h01);
		pulse(4'h2, 8'h00);
		wrr(8'h10, 8'h00);
		rdchk(8'h3a, 8'h05);
		// Software drops the master enable once sync is no longer needed.
		wrr(8'h3a, 8'h00);
		chk("buffer enable", 8'h00, {7'h0, buf_en});
		wrr(8'h3a, 8'h03);
		// A second reset in mid-run must bring every enable back to zero.
		@(posedge clk) rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdchk(8'h3a, 8'h00);
		chk("buffer enable", 8'h00, {7'h0, buf_en});
		pulse(4'h2, 8'h00);
		print_verdict();
	end
endmodule : divider_sync_control_test
`default_nettype wire
